// ===== verilog/mps_pkg.sv
// Shared constants and types for the MAC-side pin multiplexer with straps
package mps_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] REG_CTRL        = 5'h00;
  localparam logic [4:0] REG_STRAP       = 5'h18;
  localparam logic [4:0] REG_MODE        = 5'h19;
  localparam logic [4:0] REG_INT_MASK    = 5'h1a;
  localparam logic [4:0] REG_INT_STAT    = 5'h1b;
  localparam logic [4:0] REG_PHY_CTRL2   = 5'h1f;

  // Field positions
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_ISO_BIT     = 10;
  localparam int STRAP_ISO_BIT    = 3;
  localparam int STRAP_DUPLEX_BIT = 4;
  localparam int PC2_IRQ_POL_BIT  = 9;
  localparam int INT_CRS_BIT      = 0;
  localparam int INT_COL_BIT      = 1;
  localparam int INT_RXER_BIT     = 2;

  // Reset values
  localparam logic [1:0] MODE_RST     = 2'h0;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  localparam logic       IRQ_POL_RST  = 1'b0;
  localparam logic       IRQ_PIN_RST  = 1'b1;

  // MAC interface modes
  localparam logic [1:0] MODE_MII  = 2'h0;
  localparam logic [1:0] MODE_RMII = 2'h1;
  localparam logic [1:0] MODE_SMII = 2'h2;
  localparam logic [1:0] MODE_B2B  = 2'h3;

  // Strap sampling window after reset release
  localparam int         CLK_MHZ        = 100;
  localparam int         STRAP_TIME_NS  = 100;
  localparam int         STRAP_CYCLES_I = (STRAP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STRAP_LAST     = 4'(STRAP_CYCLES_I - 1);

  // SMII frame length in bits
  localparam logic [3:0] SMII_BITS = 4'ha;

  // Positions in the synchronised pin vector
  localparam int SY_W    = 12;
  localparam int SY_REF  = 0;
  localparam int SY_TXC  = 1;
  localparam int SY_TXEN = 2;
  localparam int SY_TXD0 = 3;
  localparam int SY_TXD1 = 4;
  localparam int SY_TXD2 = 5;
  localparam int SY_TXD3 = 6;
  localparam int SY_RXD0 = 7;
  localparam int SY_RXDV = 8;
  localparam int SY_RXER = 9;
  localparam int SY_COL  = 10;
  localparam int SY_CRS  = 11;

  typedef enum logic {ST_STRAP, ST_RUN} mps_phase_t;

  typedef struct packed {
    mps_phase_t  phase;
    logic [3:0]  strap_cnt;
    logic [2:0]  cfg_strap;
    logic        iso_strap;
    logic        duplex_strap;
    logic        duplex;
    logic        iso;
    logic [1:0]  mode;
    logic        irq_pol;
    logic [2:0]  int_stat;
    logic [2:0]  int_mask;
    logic        irq;
    logic        dp_valid;
    logic        dp_wr;
    logic        dp_hit;
    logic [4:0]  dp_idx;
    logic [31:0] rdata;
    logic        ref_q;
    logic        txc_q;
    logic        clk_out;
    logic        rxd0;
    logic [2:0]  rxd_hi;
    logic        rxdv;
    logic        rxer;
    logic        col;
    logic        crs;
    logic [8:0]  rx_sh;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic [7:0]  tx_byte;
    logic        tx_en;
    logic        tx_er;
    logic        tx_stb;
    logic [2:0]  ev_prev;
  } mps_st_t;

endpackage : mps_pkg

// ===== verilog/mps_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module mps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,   // Sampling clock
  input  wire logic         rst_b_in, // Async reset, active low
  input  wire logic [W-1:0] d_in,     // Asynchronous levels
  output var  logic [W-1:0] q_out     // Synchronised levels
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : mps_sync
`default_nettype wire

// ===== verilog/mps_pin_mux.sv
// MAC-side pin multiplexer with reset straps, interrupt pin and AHB-Lite registers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module mps_pin_mux
  import mps_pkg::*;
(
  input  wire logic        SYS_CLK_IN,        // System clock, 100 MHz
  input  wire logic        RST_B_IN,          // Async reset, active low
  input  wire logic        HSEL_IN,           // AHB slave select
  input  wire logic [31:0] HADDR_IN,          // AHB address
  input  wire logic [1:0]  HTRANS_IN,         // AHB transfer type
  input  wire logic        HWRITE_IN,         // AHB write
  input  wire logic [2:0]  HSIZE_IN,          // AHB size, word only
  input  wire logic [31:0] HWDATA_IN,         // AHB write data
  input  wire logic        HREADY_IN,         // AHB bus ready
  output var  logic [31:0] HRDATA_OUT,        // AHB read data
  output var  logic        HREADYOUT_OUT,     // AHB slave ready
  output var  logic        HRESP_OUT,         // AHB response, always OKAY
  input  wire logic        REF_CLK_IN,        // MAC-side reference clock
  input  wire logic        RXD0_IN,           // Receive data 0 pin, strap level
  output var  logic        RXD0_OUT,          // Receive data 0 pin drive
  output var  logic        RXD0_OE_OUT,       // Receive data 0 pin enable
  input  wire logic        RXDV_IN,           // Receive valid pin, strap level
  output var  logic        RXDV_OUT,          // Receive valid pin drive
  output var  logic        RXDV_OE_OUT,       // Receive valid pin enable
  input  wire logic        RXER_IN,           // Receive error pin, strap level
  output var  logic        RXER_OUT,          // Receive error pin drive
  output var  logic        RXER_OE_OUT,       // Receive error pin enable
  input  wire logic        COL_IN,            // Collision pin, strap level
  output var  logic        COL_OUT,           // Collision pin drive
  output var  logic        COL_OE_OUT,        // Collision pin enable
  input  wire logic        CRS_IN,            // Carrier sense pin, strap level
  output var  logic        CRS_OUT,           // Carrier sense pin drive
  output var  logic        CRS_OE_OUT,        // Carrier sense pin enable
  output var  logic [2:0]  RXD_HI_OUT,        // Receive data bits 3..1
  output var  logic        RXD_HI_OE_OUT,     // Receive data bits 3..1 enable
  output var  logic        RXC_OUT,           // Receive clock
  output var  logic        RXC_OE_OUT,        // Receive clock enable
  input  wire logic        TXC_IN,            // Transmit clock pin input
  output var  logic        TXC_OUT,           // Transmit clock pin drive
  output var  logic        TXC_OE_OUT,        // Transmit clock pin enable
  input  wire logic        TXEN_IN,           // Transmit enable from MAC
  input  wire logic [3:0]  TXD_IN,            // Transmit data; SMII data and sync
  output var  logic        IRQ_OUT,           // Interrupt pin, programmable polarity
  input  wire logic [7:0]  LINE_RX_BYTE_IN,   // Line-side receive data
  input  wire logic        LINE_RX_DV_IN,     // Line-side receive valid
  input  wire logic        LINE_CRS_IN,       // Line-side carrier sense
  input  wire logic        LINE_COL_IN,       // Line-side collision
  input  wire logic        LINE_RX_ER_IN,     // Line-side receive error
  output var  logic [7:0]  LINE_TX_BYTE_OUT,  // Transmit data to line side
  output var  logic        LINE_TX_EN_OUT,    // Transmit enable to line side
  output var  logic        LINE_TX_ER_OUT,    // Transmit error to line side
  output var  logic        LINE_TX_STB_OUT,   // Transmit data strobe, one cycle
  output var  logic        DUPLEX_OUT,        // Current duplex setting
  output var  logic [2:0]  CFG_STRAP_OUT      // Captured configuration straps
);

  mps_st_t          s;
  mps_st_t          n;
  logic [SY_W-1:0]  sy;
  logic             ref_rise;
  logic             txc_rise;
  logic             tx_rise;
  logic             drive;
  logic             mii_like;
  logic [2:0]       ev;
  logic [2:0]       ev_now;
  logic             addr_ok;

  mps_sync #(
    .W (SY_W)
  ) u_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({CRS_IN, COL_IN, RXER_IN, RXDV_IN, RXD0_IN, TXD_IN, TXEN_IN, TXC_IN,
                REF_CLK_IN}),
    .q_out    (sy)
  );

  function automatic logic edge_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : edge_rise

  function automatic logic [31:0] reg_read(input mps_st_t st, input logic [4:0] idx);
    logic [31:0] v;
    v = 32'h0;
    unique case (idx)
      REG_CTRL:
      begin
        v[CTRL_DUPLEX_BIT] = st.duplex;
        v[CTRL_ISO_BIT]    = st.iso;
      end
      REG_STRAP:
      begin
        v[2:0]              = st.cfg_strap;
        v[STRAP_ISO_BIT]    = st.iso_strap;
        v[STRAP_DUPLEX_BIT] = st.duplex_strap;
      end
      REG_MODE:      v[1:0] = st.mode;
      REG_INT_MASK:  v[2:0] = st.int_mask;
      REG_INT_STAT:  v[2:0] = st.int_stat;
      REG_PHY_CTRL2: v[PC2_IRQ_POL_BIT] = st.irq_pol;
      default:       v = 32'h0;
    endcase
    return v;
  endfunction : reg_read

  assign ref_rise = edge_rise(sy[SY_REF], s.ref_q);
  assign txc_rise = edge_rise(sy[SY_TXC], s.txc_q);
  // Back-to-back takes transmit timing from the incoming clock
  assign tx_rise  = (s.mode == MODE_B2B) ? txc_rise : ref_rise;
  assign drive    = (s.phase == ST_RUN) && !s.iso;
  assign mii_like = (s.mode == MODE_MII) || (s.mode == MODE_B2B);
  assign ev_now   = {LINE_RX_ER_IN, LINE_COL_IN, LINE_CRS_IN};
  assign ev       = ev_now & ~s.ev_prev;
  assign addr_ok  = (HADDR_IN[31:7] == 25'h0);

  always_comb
  begin
    n         = s;
    n.tx_stb  = 1'b0;
    n.ref_q   = sy[SY_REF];
    n.txc_q   = sy[SY_TXC];
    n.clk_out = sy[SY_REF];
    n.ev_prev = ev_now;

    unique case (s.phase)
      ST_STRAP:
      begin
        // Pins stay undriven so the pull levels can be read
        if (s.strap_cnt == STRAP_LAST)
        begin
          n.duplex_strap = sy[SY_RXD0];
          n.duplex       = sy[SY_RXD0];
          n.cfg_strap[2] = sy[SY_RXDV];
          n.iso_strap    = sy[SY_RXER];
          n.iso          = sy[SY_RXER];
          n.cfg_strap[0] = sy[SY_COL];
          n.cfg_strap[1] = sy[SY_CRS];
          n.phase        = ST_RUN;
        end
        else
        begin
          n.strap_cnt = s.strap_cnt + 4'h1;
        end
      end
      ST_RUN:
      begin
        if (ref_rise)
        begin
          unique case (s.mode)
            MODE_RMII:
            begin
              n.rxd0   = LINE_RX_BYTE_IN[0];
              n.rxd_hi = {2'b00, LINE_RX_BYTE_IN[1]};
              n.rxdv   = LINE_CRS_IN | LINE_RX_DV_IN;
              n.rxer   = LINE_RX_ER_IN;
              n.col    = 1'b0;
              n.crs    = 1'b0;
            end
            MODE_SMII:
            begin
              // Frame: carrier, valid, then data LSB first
              if (sy[SY_TXD1])
              begin
                n.rxd0  = LINE_CRS_IN;
                n.rx_sh = {LINE_RX_BYTE_IN, LINE_RX_DV_IN};
              end
              else
              begin
                n.rxd0  = s.rx_sh[0];
                n.rx_sh = {1'b0, s.rx_sh[8:1]};
              end
            end
            default:
            begin
              n.rxd0   = LINE_RX_BYTE_IN[0];
              n.rxd_hi = LINE_RX_BYTE_IN[3:1];
              n.rxdv   = LINE_RX_DV_IN;
              n.rxer   = LINE_RX_ER_IN;
              n.col    = LINE_COL_IN;
              n.crs    = LINE_CRS_IN;
            end
          endcase
        end

        // Transmit inputs are ignored while isolated
        if (tx_rise && !s.iso)
        begin
          unique case (s.mode)
            MODE_RMII:
            begin
              n.tx_byte = {6'h00, sy[SY_TXD1], sy[SY_TXD0]};
              n.tx_en   = sy[SY_TXEN];
              n.tx_er   = 1'b0;
              n.tx_stb  = 1'b1;
            end
            MODE_SMII:
            begin
              // Sync marks the first bit of a frame; the one before it is complete
              if (sy[SY_TXD1])
              begin
                if (s.tx_cnt == SMII_BITS)
                begin
                  n.tx_er   = s.tx_sh[0];
                  n.tx_en   = s.tx_sh[1];
                  n.tx_byte = s.tx_sh[9:2];
                  n.tx_stb  = 1'b1;
                end
                n.tx_cnt = 4'h1;
              end
              else if (s.tx_cnt != SMII_BITS)
              begin
                n.tx_cnt = s.tx_cnt + 4'h1;
              end
              n.tx_sh = {sy[SY_TXD0], s.tx_sh[9:1]};
            end
            default:
            begin
              n.tx_byte = {4'h0, sy[SY_TXD3], sy[SY_TXD2], sy[SY_TXD1], sy[SY_TXD0]};
              n.tx_en   = sy[SY_TXEN];
              n.tx_er   = 1'b0;
              n.tx_stb  = 1'b1;
            end
          endcase
        end
      end
    endcase

    // Register writes land in the data phase
    if (s.dp_valid && s.dp_wr && s.dp_hit)
    begin
      unique case (s.dp_idx)
        REG_CTRL:
        begin
          n.duplex = HWDATA_IN[CTRL_DUPLEX_BIT];
          n.iso    = HWDATA_IN[CTRL_ISO_BIT];
        end
        REG_MODE:      n.mode     = HWDATA_IN[1:0];
        REG_INT_MASK:  n.int_mask = HWDATA_IN[2:0];
        REG_PHY_CTRL2: n.irq_pol  = HWDATA_IN[PC2_IRQ_POL_BIT];
        default:       n.mode     = n.mode;
      endcase
    end

    // Write-one-to-clear; a new event in the same cycle wins
    if (s.dp_valid && s.dp_wr && s.dp_hit && (s.dp_idx == REG_INT_STAT))
    begin
      n.int_stat = (s.int_stat & ~HWDATA_IN[2:0]) | ev;
    end
    else
    begin
      n.int_stat = s.int_stat | ev;
    end

    n.irq = (|(n.int_stat & n.int_mask)) ? n.irq_pol : ~n.irq_pol;

    // Address phase; read data reflects this edge's updates
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1])
    begin
      n.dp_valid = 1'b1;
      n.dp_wr    = HWRITE_IN;
      n.dp_hit   = addr_ok;
      n.dp_idx   = HADDR_IN[6:2];
      n.rdata    = (!HWRITE_IN && addr_ok) ? reg_read(n, HADDR_IN[6:2]) : 32'h0;
    end
    else
    begin
      n.dp_valid = 1'b0;
      n.dp_wr    = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      s          <= '0;
      s.phase    <= ST_STRAP;
      s.mode     <= MODE_RST;
      s.int_mask <= INT_MASK_RST;
      s.irq_pol  <= IRQ_POL_RST;
      s.irq      <= IRQ_PIN_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign HRDATA_OUT       = s.rdata;
  assign HREADYOUT_OUT    = 1'b1;
  assign HRESP_OUT        = 1'b0;
  assign RXD0_OUT         = s.rxd0;
  assign RXD0_OE_OUT      = drive;
  assign RXDV_OUT         = s.rxdv;
  assign RXDV_OE_OUT      = drive && (s.mode != MODE_SMII);
  assign RXER_OUT         = s.rxer;
  assign RXER_OE_OUT      = drive && (s.mode != MODE_SMII);
  assign COL_OUT          = s.col;
  assign COL_OE_OUT       = drive && mii_like;
  assign CRS_OUT          = s.crs;
  assign CRS_OE_OUT       = drive && mii_like;
  assign RXD_HI_OUT       = s.rxd_hi;
  assign RXD_HI_OE_OUT    = drive && (s.mode != MODE_SMII);
  assign RXC_OUT          = s.clk_out;
  assign RXC_OE_OUT       = drive && mii_like;
  assign TXC_OUT          = s.clk_out;
  assign TXC_OE_OUT       = drive && (s.mode == MODE_MII);
  assign IRQ_OUT          = s.irq;
  assign LINE_TX_BYTE_OUT = s.tx_byte;
  assign LINE_TX_EN_OUT   = s.tx_en;
  assign LINE_TX_ER_OUT   = s.tx_er;
  assign LINE_TX_STB_OUT  = s.tx_stb;
  assign DUPLEX_OUT       = s.duplex;
  assign CFG_STRAP_OUT    = s.cfg_strap;

endmodule : mps_pin_mux
`default_nettype wire

// ===== testbench/mps_pin_mux_props.sv
// Checker for the MAC-side pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module mps_pin_mux_props
  import mps_pkg::*;
(
  input wire logic        SYS_CLK_IN,    // Clock
  input wire logic        RST_B_IN,      // Reset
  input wire logic        HSEL_IN,       // Select
  input wire logic [31:0] HADDR_IN,      // Address
  input wire logic [1:0]  HTRANS_IN,     // Type
  input wire logic        HWRITE_IN,     // Write
  input wire logic [31:0] HWDATA_IN,     // Wdata
  input wire logic        HREADY_IN,     // Ready
  input wire logic        RXD0_IN,       // Pin
  input wire logic        RXDV_IN,       // Pin
  input wire logic        RXER_IN,       // Pin
  input wire logic        COL_IN,        // Pin
  input wire logic        CRS_IN,        // Pin
  input wire logic        RXD0_OE_OUT,   // Enable
  input wire logic        RXDV_OE_OUT,   // Enable
  input wire logic        COL_OE_OUT,    // Enable
  input wire logic        CRS_OE_OUT,    // Enable
  input wire logic        TXC_OE_OUT,    // Enable
  input wire logic        IRQ_OUT,       // Interrupt
  input wire logic        LINE_CRS_IN,   // Event
  input wire logic        LINE_COL_IN,   // Event
  input wire logic        LINE_RX_ER_IN, // Event
  input wire logic        DUPLEX_OUT,    // Duplex
  input wire logic [2:0]  CFG_STRAP_OUT  // Straps
);
  logic [3:0] cnt;
  logic [4:0] seen;
  logic       wr_dp;
  logic       ev;
  logic       pol_m;
  logic [4:0] wr_idx;
  logic [2:0] line_q;
  logic [2:0] mask_m;
  logic [1:0] mode_m;
  logic       any_oe;
  assign ev = |({LINE_RX_ER_IN, LINE_COL_IN, LINE_CRS_IN} & ~line_q);
  assign any_oe = RXD0_OE_OUT | RXDV_OE_OUT | COL_OE_OUT | CRS_OE_OUT | TXC_OE_OUT;
  // Mirrors of mode, mask and polarity, snooped off the bus
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      cnt    <= 4'h0;
      seen   <= 5'h00;
      wr_dp  <= 1'b0;
      wr_idx <= 5'h00;
      line_q <= 3'h0;
      mask_m <= INT_MASK_RST;
      mode_m <= MODE_RST;
      pol_m  <= IRQ_POL_RST;
    end
    else
    begin
      if (cnt != 4'hf)
        cnt <= cnt + 4'h1;
      // Mid-window sample, pins are pulls only
      if (cnt == 4'h5)
        seen <= {RXER_IN, RXD0_IN, RXDV_IN, CRS_IN, COL_IN};
      line_q <= {LINE_RX_ER_IN, LINE_COL_IN, LINE_CRS_IN};
      wr_dp  <= HSEL_IN & HREADY_IN & HTRANS_IN[1] & HWRITE_IN & (HADDR_IN[31:7] == 25'h0);
      wr_idx <= HADDR_IN[6:2];
      if (wr_dp && wr_idx == REG_MODE)
        mode_m <= HWDATA_IN[1:0];
      if (wr_dp && wr_idx == REG_INT_MASK)
        mask_m <= HWDATA_IN[2:0];
      if (wr_dp && wr_idx == REG_PHY_CTRL2)
        pol_m <= HWDATA_IN[PC2_IRQ_POL_BIT];
    end
  end
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  chk_strap_cfg: assert property (cnt >= 4'hc |-> CFG_STRAP_OUT == seen[2:0])
    else $error("config straps differ from pin levels");
  chk_strap_dup: assert property (cnt == 4'hc |-> DUPLEX_OUT == seen[3])
    else $error("duplex differs from strap level");
  chk_oe_strap: assert property (cnt <= 4'h9 |-> !any_oe)
    else $error("pin driven during strap window");
  chk_iso_quiet: assert property (cnt == 4'hf && seen[4] |-> !any_oe)
    else $error("pin driven while isolated");
  chk_irq_cause: assert property ($changed(IRQ_OUT) |-> $past(wr_dp | ev))
    else $error("interrupt moved without cause");
  chk_irq_pol: assert property (mask_m == 3'h0 |-> IRQ_OUT == !pol_m)
    else $error("idle interrupt level wrong");
  chk_txc_dir: assert property (cnt == 4'hf && !seen[4] && mode_m[0] == mode_m[1]
    |-> TXC_OE_OUT == (mode_m == MODE_MII))
    else $error("transmit clock direction wrong");
  chk_rmii_pins: assert property (cnt == 4'hf && !seen[4] && mode_m == MODE_RMII
    |-> RXDV_OE_OUT && !COL_OE_OUT && !CRS_OE_OUT)
    else $error("reduced mode pin enables wrong");
endmodule : mps_pin_mux_props
bind mps_pin_mux mps_pin_mux_props u_props (.*);
`default_nettype wire

// ===== testbench/mps_mac_model.sv
// Behavioural MAC on the far side of the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module mps_mac_model (
  output var  logic       ref_clk_out, // Reference clock
  output wire logic       txc_out,     // Transmit clock, peer mode
  output var  logic       txen_out,    // Transmit enable
  output var  logic [3:0] txd_out,     // Transmit data
  input  wire logic       txc_run_in,  // Run peer transmit clock
  input  wire logic       rxd0_in      // Receive data 0 wire
);
  // Oscillator runs free; phase offset keeps it unrelated
  initial
  begin
    ref_clk_out = 1'b0;
    #3;
    forever #80 ref_clk_out = ~ref_clk_out;
  end
  initial
  begin
    txen_out = 1'b0;
    txd_out  = 4'h0;
  end
  assign txc_out = txc_run_in & ref_clk_out;
  task automatic put_nibble(input logic en, input logic [3:0] d);
    @(negedge ref_clk_out);
    txen_out <= en;
    txd_out  <= d;
  endtask : put_nibble
  // Serial frame plus a trailing sync; samples the serial receive bit
  task automatic send_smii(input logic [9:0] fr, output logic [9:0] rx);
    for (int i = 0; i <= 10; i++)
    begin
      @(negedge ref_clk_out);
      if (i > 0)
        rx[i-1] = rxd0_in;
      txd_out[1] <= (i == 0) || (i == 10);
      txd_out[0] <= (i < 10) ? fr[i] : 1'b0;
    end
    @(negedge ref_clk_out);
    txd_out <= 4'h0;
  endtask : send_smii
endmodule : mps_mac_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the MAC-side pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mps_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0]  htrans = 2'h0;
  logic [4:0]  strap = 5'h00; // {iso, dup, b2, b1, b0}
  logic [7:0]  lbyte = 8'h00;
  logic [3:0]  lsig = 4'h0;   // {dv, crs, col, er}
  logic        txc_run = 1'b0;
  logic [9:0]  smii_rx;
  logic [3:0]  txd;
  wire logic   ref_clk;
  wire logic   txc;
  wire logic   txen;
  wire logic   hready;
  int          stb_n = 0;
  int          err_total = 0;
  int          check_count = 0;
  // Pin wires: driven value when enabled, else the strap resistor
  wire logic rxd0_w = DUT.RXD0_OE_OUT ? DUT.RXD0_OUT : strap[3];
  wire logic rxdv_w = DUT.RXDV_OE_OUT ? DUT.RXDV_OUT : strap[2];
  wire logic rxer_w = DUT.RXER_OE_OUT ? DUT.RXER_OUT : strap[4];
  wire logic col_w = DUT.COL_OE_OUT ? DUT.COL_OUT : strap[0];
  wire logic crs_w = DUT.CRS_OE_OUT ? DUT.CRS_OUT : strap[1];
  always #5 clk = ~clk;
  // Counts strobe cycles, so a pulse longer than one cycle shows up
  always @(posedge clk)
    if (DUT.LINE_TX_STB_OUT === 1'b1)
      stb_n <= stb_n + 1;
  mps_pin_mux DUT (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(), .HREADYOUT_OUT(hready), .HRESP_OUT(),
    .REF_CLK_IN(ref_clk), .RXD0_IN(rxd0_w), .RXD0_OUT(), .RXD0_OE_OUT(),
    .RXDV_IN(rxdv_w), .RXDV_OUT(), .RXDV_OE_OUT(), .RXER_IN(rxer_w), .RXER_OUT(),
    .RXER_OE_OUT(), .COL_IN(col_w), .COL_OUT(), .COL_OE_OUT(), .CRS_IN(crs_w),
    .CRS_OUT(), .CRS_OE_OUT(), .RXD_HI_OUT(), .RXD_HI_OE_OUT(), .RXC_OUT(),
    .RXC_OE_OUT(), .TXC_IN(txc), .TXC_OUT(), .TXC_OE_OUT(), .TXEN_IN(txen),
    .TXD_IN(txd), .IRQ_OUT(), .LINE_RX_BYTE_IN(lbyte), .LINE_RX_DV_IN(lsig[3]),
    .LINE_CRS_IN(lsig[2]), .LINE_COL_IN(lsig[1]), .LINE_RX_ER_IN(lsig[0]),
    .LINE_TX_BYTE_OUT(), .LINE_TX_EN_OUT(), .LINE_TX_ER_OUT(), .LINE_TX_STB_OUT(),
    .DUPLEX_OUT(), .CFG_STRAP_OUT()
  );
  mps_mac_model MAC (
    .ref_clk_out(ref_clk), .txc_out(txc), .txen_out(txen), .txd_out(txd),
    .txc_run_in(txc_run), .rxd0_in(rxd0_w)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {25'h0, idx, 2'b00};
    htrans <= 2'h2;
    do @(posedge clk); while (DUT.HREADYOUT_OUT !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (DUT.HREADYOUT_OUT !== 1'b1);
    rdata = DUT.HRDATA_OUT;
  endtask : bus
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rdchk(input logic [4:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rdata, exp);
  endtask : rdchk
  // Settle past the edge before looking at the registered pin
  task automatic irq_is(input logic exp);
    @(negedge clk);
    chk(DUT.IRQ_OUT, exp);
  endtask : irq_is
  task automatic reset_straps(input logic [4:0] s);
    @(posedge clk);
    rst_b <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (14) @(posedge clk);
    chk(DUT.CFG_STRAP_OUT, s[2:0]);
    chk(DUT.DUPLEX_OUT, s[3]);
    rdchk(REG_STRAP, {27'h0, s[3], s[4], s[2:0]});
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rdata & 32'h500, {21'h0, s[4], 1'b0, s[3], 8'h0});
    chk({DUT.RXD0_OE_OUT, DUT.RXDV_OE_OUT, DUT.COL_OE_OUT, DUT.CRS_OE_OUT,
         DUT.TXC_OE_OUT}, s[4] ? 5'h00 : 5'h1f);
  endtask : reset_straps
  task automatic t_rx(input logic [1:0] m, input logic [3:0] nib, input logic dv,
                      input logic [5:0] sig);
    wr(REG_MODE, {30'h0, m});
    lbyte <= 8'h5a;
    lsig  <= 4'b0100;
    repeat (2) @(negedge ref_clk);
    chk({DUT.RXD_HI_OUT, DUT.RXD0_OUT}, nib);
    chk(DUT.RXDV_OUT, dv);
    chk({DUT.RXER_OUT, DUT.COL_OUT, DUT.CRS_OUT, DUT.RXC_OE_OUT, DUT.RXD_HI_OE_OUT,
         DUT.RXER_OE_OUT}, sig);
  endtask : t_rx
  task automatic tx_step(input logic [1:0] m, input logic run, input logic [3:0] nib,
                         input logic [7:0] exp);
    txc_run <= run;
    wr(REG_MODE, {30'h0, m});
    MAC.put_nibble(1'b1, nib);
    repeat (3) @(negedge ref_clk);
    chk({DUT.LINE_TX_EN_OUT, DUT.LINE_TX_BYTE_OUT}, {1'b1, exp});
    chk({DUT.TXC_OUT & DUT.TXC_OE_OUT, DUT.RXC_OUT}, {m == MODE_MII, 1'b1});
  endtask : tx_step
  task automatic t_smii();
    int n0;
    wr(REG_MODE, {30'h0, MODE_SMII});
    lbyte <= 8'ha5;
    lsig  <= 4'b1100;
    // Let a strobe from the previous mode be counted first
    repeat (2) @(negedge clk);
    n0 = stb_n;
    MAC.send_smii({8'h3c, 1'b1, 1'b0}, smii_rx);
    chk(smii_rx, {8'ha5, 1'b1, 1'b1});
    chk({DUT.LINE_TX_ER_OUT, DUT.LINE_TX_EN_OUT, DUT.LINE_TX_BYTE_OUT}, 10'h13c);
    chk(stb_n - n0, 32'h1);
  endtask : t_smii
  task automatic t_irq();
    @(posedge clk);
    lsig <= 4'h0;
    wr(REG_INT_STAT, 32'h7);
    rdchk(REG_INT_STAT, 32'h0);
    irq_is(1'b1);
    @(posedge clk);
    lsig <= 4'b0100;
    rdchk(REG_INT_STAT, 32'h1);
    irq_is(1'b1);
    wr(REG_INT_MASK, 32'h1);
    irq_is(1'b0);
    wr(REG_PHY_CTRL2, 32'h200);
    irq_is(1'b1);
    wr(REG_INT_STAT, 32'h1);
    irq_is(1'b0);
    @(posedge clk);
    lsig <= 4'b0011;
    rdchk(REG_INT_STAT, 32'h6);
    irq_is(1'b0);
    wr(REG_INT_MASK, 32'h2);
    irq_is(1'b1);
    wr(REG_PHY_CTRL2, 32'h0);
    irq_is(1'b0);
  endtask : t_irq
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100_000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    reset_straps(5'b01101);
    wr(5'h05, 32'hffffffff);
    rdchk(5'h05, 32'h0);
    rdchk(REG_MODE, {30'h0, MODE_RST});
    rdchk(REG_INT_MASK, {29'h0, INT_MASK_RST});
    t_rx(MODE_MII, 4'ha, 1'b0, 6'h0f);
    t_rx(MODE_RMII, 4'h2, 1'b1, 6'h03);
    tx_step(MODE_MII, 1'b0, 4'hb, 8'h0b);
    tx_step(MODE_RMII, 1'b0, 4'hb, 8'h03);
    tx_step(MODE_B2B, 1'b0, 4'h6, 8'h03);
    tx_step(MODE_B2B, 1'b1, 4'h6, 8'h06);
    t_smii();
    t_irq();
    wr(REG_CTRL, 32'h0);
    @(negedge clk);
    chk(DUT.DUPLEX_OUT, 1'b0);
    reset_straps(5'b10010);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
